// ---- logic/adc_regs_pkg.sv ----
/*
  Constants, field positions and types of the converter's user register bank.
  Assumes the serial framing logic has already decoded address and data words.
*/
package adc_regs_pkg;
  // ---------------------------------------------------------------
  // Widths and addresses
  // ---------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int CONV_W = 32;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 16'h0001;
  localparam logic [ADDR_W-1:0] ADDR_GAIN    = 16'h0004;
  localparam logic [ADDR_W-1:0] ADDR_THRESH  = 16'h0005;

  // ---------------------------------------------------------------
  // Control fields
  // ---------------------------------------------------------------
  localparam int BIT_RD_THRESH   = 14;
  localparam int BIT_RD_GAIN     = 13;
  localparam int BIT_RD_STATUS   = 11;
  localparam int BIT_SYNC        = 9;
  localparam int BIT_REF_BYPASS  = 7;
  localparam int BIT_POWER_OFF   = 3;
  localparam int BIT_LOW_POWER   = 2;
  localparam int BIT_REF_BUF_OFF = 1;
  localparam int BIT_AMP_DISABLE = 0;
  localparam logic [DATA_W-1:0] CTRL_KEEP_MASK = 16'h008F;
  localparam logic [DATA_W-1:0] CTRL_SELF_CLEAR_MASK = 16'h7A00;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] CTRL_RESET   = 16'h0000;
  localparam logic [DATA_W-1:0] GAIN_RESET   = 16'hA000;
  localparam logic [DATA_W-1:0] GAIN_UNITY   = 16'h8000;
  localparam logic [DATA_W-1:0] THRESH_RESET = 16'hCCCC;
  localparam logic [DATA_W-1:0] ZERO_WORD    = 16'h0000;

  // ---------------------------------------------------------------
  // Status fields
  // ---------------------------------------------------------------
  localparam int ST_PART      = 15;
  localparam int ST_SETTLED   = 10;
  localparam int ST_ZERO      = 9;
  localparam int ST_OVR       = 8;
  localparam int ST_REF_ON    = 4;
  localparam int ST_AMP_USED  = 3;
  localparam int ST_LOW_POWER = 2;
  localparam int ST_DECIM_LSB = 0;
  localparam int DECIM_W      = 2;
  localparam logic [DATA_W-1:0] ST_FIXED_ONES = 16'h4040;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int FS_RUN_LIMIT   = 4;
  localparam int CLK_PERIOD_NS  = 4;
  localparam int SETTLE_TIME_NS = 100000;
  localparam int SETTLE_CYCLES  = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SEL_CONV   = 2'b00,
    SEL_THRESH = 2'b01,
    SEL_GAIN   = 2'b10,
    SEL_STATUS = 2'b11
  } read_sel_t;
endpackage : adc_regs_pkg

// ---- logic/overrange_detect.sv ----
/*
  Overrange detector: threshold compare on first-stage filter output plus a
  run counter on the modulator full-scale indication.
  Assumes sample_mag is an unsigned magnitude, one pulse per first-stage sample.
*/
`timescale 1ns/10ps
module overrange_detect
  import adc_regs_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              sample_valid,
  input  wire logic [DATA_W-1:0] sample_mag,
  input  wire logic [DATA_W-1:0] threshold,
  input  wire logic              mod_tick,
  input  wire logic              mod_over_fs,
  output logic                   overrange_flag
);
  localparam logic [2:0] RUN_LIMIT = 3'(FS_RUN_LIMIT);

  logic [2:0] run_r;
  logic       full_trip;

  // Fifth consecutive over-scale modulator sample trips at once
  assign full_trip = mod_tick && mod_over_fs && (run_r == RUN_LIMIT);

  always_ff @(posedge clock) begin
    if (rst) begin
      run_r <= 3'h0;
    end else if (mod_tick) begin
      if (!mod_over_fs) begin
        run_r <= 3'h0;
      end else if (run_r != RUN_LIMIT) begin
        run_r <= run_r + 3'h1;
      end
    end
  end

  // Trip wins over an in-range sample in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      overrange_flag <= 1'b0;
    end else if (full_trip) begin
      overrange_flag <= 1'b1;
    end else if (sample_valid) begin
      overrange_flag <= (sample_mag > threshold);
    end
  end

  property p_fs_trip;
    @(posedge clock) disable iff (rst)
    full_trip |=> overrange_flag;
  endproperty
  a_fs_trip: assert property (p_fs_trip) else $error("full-scale run did not trip");

  property p_thresh;
    @(posedge clock) disable iff (rst)
    sample_valid && (sample_mag > threshold) |=> overrange_flag;
  endproperty
  a_thresh: assert property (p_thresh) else $error("threshold exceed not flagged");

  property p_fs_cover;
    @(posedge clock) disable iff (rst)
    full_trip;
  endproperty
  c_fs_cover: cover property (p_fs_cover);
endmodule : overrange_detect

// ---- logic/adc_control_status_registers.sv ----
/*
  User register bank of a sigma-delta converter: control, status, digital
  gain and overrange threshold, plus read selection and settling tracking.
  Assumes the serial port logic delivers decoded one-cycle write and read
  strobes in the clock domain, and that the filter datapath is outside.
*/
`timescale 1ns/10ps
module adc_control_status_registers
  import adc_regs_pkg::*;
#(
  parameter int                SETTLE_CNT = SETTLE_CYCLES,
  parameter logic              PART_IDENT = 1'b0 // Arbitrary value
)
(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              wr_strobe,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              rd_strobe,
  input  wire logic [CONV_W-1:0] conv_result,
  input  wire logic [DECIM_W-1:0] decimation_setting,
  input  wire logic              sample_valid,
  input  wire logic [DATA_W-1:0] sample_mag,
  input  wire logic              mod_tick,
  input  wire logic              mod_over_fs,
  output logic [CONV_W-1:0]      rd_data,
  output logic                   rd_valid,
  output logic                   sync_start,
  output logic                   power_off_bit,
  output logic                   low_power_flag,
  output logic                   ref_buf_off,
  output logic                   ref_bypass,
  output logic                   input_amp_disable,
  output logic [DATA_W-1:0]      digital_gain,
  output logic [DATA_W-1:0]      overrange_threshold,
  output logic                   filter_settled,
  output logic                   overrange_flag
);
  localparam int CNT_W = $clog2(SETTLE_CNT + 1);
  localparam logic [CNT_W-1:0] CNT_DONE = CNT_W'(SETTLE_CNT);
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
  localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(0);

  // ---------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------
  logic              ctrl_wr;
  logic              gain_wr;
  logic              thresh_wr;
  logic              sel_wr;
  logic [DATA_W-1:0] control_r;
  logic [DATA_W-1:0] control_nxt;
  logic [DATA_W-1:0] status_word;
  logic              range_det;
  read_sel_t         read_sel_r;
  read_sel_t         read_sel_nxt;
  logic [CNT_W-1:0]  settle_cnt_r;

  assign ctrl_wr   = wr_strobe && (wr_addr == ADDR_CONTROL);
  assign gain_wr   = wr_strobe && (wr_addr == ADDR_GAIN);
  assign thresh_wr = wr_strobe && (wr_addr == ADDR_THRESH);
  assign sel_wr    = ctrl_wr && (wr_data[BIT_RD_THRESH] || wr_data[BIT_RD_GAIN]
                                 || wr_data[BIT_RD_STATUS]);

  // Self-clearing bits act on the write only and are masked out of storage
  assign control_nxt = wr_data & CTRL_KEEP_MASK;

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      control_r <= CTRL_RESET;
    end else if (ctrl_wr) begin
      control_r <= control_nxt;
    end
  end

  assign power_off_bit     = control_r[BIT_POWER_OFF];
  assign low_power_flag    = control_r[BIT_LOW_POWER];
  assign ref_buf_off       = control_r[BIT_REF_BUF_OFF];
  assign input_amp_disable = control_r[BIT_AMP_DISABLE];

  // Bypass only meaningful with the buffer powered down
  always_ff @(posedge clock) begin
    if (rst) begin
      ref_bypass <= 1'b0;
    end else begin
      ref_bypass <= control_r[BIT_REF_BYPASS] && control_r[BIT_REF_BUF_OFF];
    end
  end

  // ---------------------------------------------------------------
  // Gain and threshold registers
  // ---------------------------------------------------------------
  // Power-down leaves these untouched so a wake-up needs no reload
  always_ff @(posedge clock) begin
    if (rst) begin
      digital_gain <= GAIN_RESET;
    end else if (gain_wr) begin
      digital_gain <= wr_data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      overrange_threshold <= THRESH_RESET;
    end else if (thresh_wr) begin
      overrange_threshold <= wr_data;
    end
  end

  // ---------------------------------------------------------------
  // Synchronisation pulse
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      sync_start <= 1'b0;
    end else begin
      sync_start <= ctrl_wr && wr_data[BIT_SYNC];
    end
  end

  // ---------------------------------------------------------------
  // Filter settling
  // ---------------------------------------------------------------
  // Restarted by sync and held while powered down
  always_ff @(posedge clock) begin
    if (rst || sync_start || power_off_bit) begin
      settle_cnt_r <= CNT_ZERO;
    end else if (settle_cnt_r != CNT_DONE) begin
      settle_cnt_r <= settle_cnt_r + CNT_ONE;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || sync_start || power_off_bit) begin
      filter_settled <= 1'b0;
    end else begin
      filter_settled <= (settle_cnt_r == CNT_DONE);
    end
  end

  // ---------------------------------------------------------------
  // Overrange
  // ---------------------------------------------------------------
  overrange_detect u_range (
    .clock          (clock),
    .rst            (rst),
    .sample_valid   (sample_valid),
    .sample_mag     (sample_mag),
    .threshold      (overrange_threshold),
    .mod_tick       (mod_tick),
    .mod_over_fs    (mod_over_fs),
    .overrange_flag (range_det)
  );

  always_ff @(posedge clock) begin
    if (rst) begin
      overrange_flag <= 1'b0;
    end else begin
      overrange_flag <= range_det;
    end
  end

  // ---------------------------------------------------------------
  // Status word
  // ---------------------------------------------------------------
  always_comb begin
    status_word                           = ST_FIXED_ONES;
    status_word[ST_PART]                  = PART_IDENT;
    status_word[ST_SETTLED]               = filter_settled;
    status_word[ST_ZERO]                  = 1'b0;
    status_word[ST_OVR]                   = range_det;
    status_word[ST_REF_ON]                = !ref_buf_off && !power_off_bit;
    status_word[ST_AMP_USED]              = !input_amp_disable && !power_off_bit;
    status_word[ST_LOW_POWER]             = low_power_flag;
    status_word[ST_DECIM_LSB+:DECIM_W]    = decimation_setting;
  end

  // ---------------------------------------------------------------
  // Read selection
  // ---------------------------------------------------------------
  // Fixed priority if a host breaks the one-select-per-write convention
  always_comb begin
    read_sel_nxt = read_sel_r;
    if (rd_strobe) begin
      read_sel_nxt = SEL_CONV;
    end
    if (ctrl_wr) begin
      if (wr_data[BIT_RD_THRESH]) begin
        read_sel_nxt = SEL_THRESH;
      end else if (wr_data[BIT_RD_GAIN]) begin
        read_sel_nxt = SEL_GAIN;
      end else if (wr_data[BIT_RD_STATUS]) begin
        read_sel_nxt = SEL_STATUS;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      read_sel_r <= SEL_CONV;
    end else begin
      read_sel_r <= read_sel_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  // Register contents go out in the upper word, low word zero
  always_ff @(posedge clock) begin
    if (rst) begin
      rd_data <= {ZERO_WORD, ZERO_WORD};
    end else if (rd_strobe) begin
      unique case (read_sel_r)
        SEL_CONV:   rd_data <= conv_result;
        SEL_THRESH: rd_data <= {overrange_threshold, ZERO_WORD};
        SEL_GAIN:   rd_data <= {digital_gain, ZERO_WORD};
        SEL_STATUS: rd_data <= {status_word, ZERO_WORD};
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_strobe;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_rd_thresh;
    @(posedge clock) disable iff (rst)
    rd_strobe && (read_sel_r == SEL_THRESH) && !thresh_wr
      |=> rd_valid && (rd_data == {overrange_threshold, ZERO_WORD});
  endproperty
  a_rd_thresh: assert property (p_rd_thresh) else $error("threshold read wrong");

  property p_rd_gain;
    @(posedge clock) disable iff (rst)
    rd_strobe && (read_sel_r == SEL_GAIN) && !gain_wr
      |=> rd_valid && (rd_data == {digital_gain, ZERO_WORD});
  endproperty
  a_rd_gain: assert property (p_rd_gain) else $error("gain read wrong");

  property p_rd_status;
    @(posedge clock) disable iff (rst)
    rd_strobe && (read_sel_r == SEL_STATUS)
      |=> rd_data[CONV_W-1-:DATA_W] == $past(status_word);
  endproperty
  a_rd_status: assert property (p_rd_status) else $error("status read wrong");

  property p_sync;
    @(posedge clock) disable iff (rst)
    ctrl_wr && wr_data[BIT_SYNC] |=> sync_start
      ##1 (!filter_settled && (sync_start == $past(ctrl_wr && wr_data[BIT_SYNC])));
  endproperty
  a_sync: assert property (p_sync) else $error("sync did not restart");

  property p_self_clear;
    @(posedge clock) disable iff (rst)
    ctrl_wr |=> (control_r & CTRL_SELF_CLEAR_MASK) == ZERO_WORD;
  endproperty
  a_self_clear: assert property (p_self_clear) else $error("self-clear bit kept");

  property p_bypass;
    @(posedge clock) disable iff (rst)
    ##1 ref_bypass == $past(control_r[BIT_REF_BYPASS] && control_r[BIT_REF_BUF_OFF]);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass without buffer off");

  property p_power;
    @(posedge clock) disable iff (rst)
    ctrl_wr && wr_data[BIT_POWER_OFF] |=> power_off_bit && $stable(digital_gain)
      && $stable(overrange_threshold) ##1 !filter_settled;
  endproperty
  a_power: assert property (p_power) else $error("power-down misbehaved");

  property p_reset;
    @(posedge clock)
    rst |=> (control_r == CTRL_RESET) && (digital_gain == GAIN_RESET)
      && (overrange_threshold == THRESH_RESET) && (read_sel_r == SEL_CONV);
  endproperty
  a_reset: assert property (p_reset) else $error("bad reset value");

  property p_status_fixed;
    @(posedge clock) disable iff (rst)
    !status_word[ST_ZERO] && (status_word[ST_PART] == PART_IDENT)
      && (status_word[ST_DECIM_LSB+:DECIM_W] == decimation_setting);
  endproperty
  a_status_fixed: assert property (p_status_fixed) else $error("status fixed bits");

  property p_consume;
    @(posedge clock) disable iff (rst)
    rd_strobe && !sel_wr |=> read_sel_r == SEL_CONV;
  endproperty
  a_consume: assert property (p_consume) else $error("select not consumed");

  property p_settle;
    @(posedge clock) disable iff (rst)
    $rose(filter_settled) |-> $past(settle_cnt_r) == CNT_DONE;
  endproperty
  a_settle: assert property (p_settle) else $error("settled too early");

  property p_cov_thresh;
    @(posedge clock) disable iff (rst)
    rd_strobe && (read_sel_r == SEL_THRESH);
  endproperty
  c_cov_thresh: cover property (p_cov_thresh);

  property p_cov_sync;
    @(posedge clock) disable iff (rst)
    sync_start;
  endproperty
  c_cov_sync: cover property (p_cov_sync);

  property p_cov_settled;
    @(posedge clock) disable iff (rst)
    $rose(filter_settled);
  endproperty
  c_cov_settled: cover property (p_cov_settled);
endmodule : adc_control_status_registers

// ---- verification/reg_host_model.sv ----
/*
  Host-side model of the register port: issues decoded writes and reads.
  Assumes the bench owns the clock and calls the tasks from a single process.
*/
`timescale 1ns/10ps
module reg_host_model
  import adc_regs_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rd_valid,
  input  wire logic [CONV_W-1:0] rd_data,
  output logic                   wr_strobe,
  output logic [ADDR_W-1:0]      wr_addr,
  output logic [DATA_W-1:0]      wr_data,
  output logic                   rd_strobe
);
  // ---------------------------------------------------------------
  // Idle state
  // ---------------------------------------------------------------
  initial begin
    wr_strobe = 1'b0;
    wr_addr   = 16'h0000;
    wr_data   = 16'h0000;
    rd_strobe = 1'b0;
  end

  // ---------------------------------------------------------------
  // Transfers
  // ---------------------------------------------------------------
  // One address and one 16-bit word per write
  // No sync pin here, so sync never meets a write
  task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge clock);
    wr_strobe = 1'b1;
    wr_addr   = a;
    wr_data   = d;
    @(negedge clock);
    wr_strobe = 1'b0;
    // Released lines show junk so a stale word cannot pass
    wr_addr   = ~a;
    wr_data   = ~d;
  endtask : write_reg

  task automatic read_reg(output logic [CONV_W-1:0] q, output logic v);
    @(negedge clock);
    rd_strobe = 1'b1;
    @(negedge clock);
    rd_strobe = 1'b0;
    v = rd_valid;
    q = rd_data;
  endtask : read_reg
endmodule : reg_host_model

// ---- verification/adc_control_status_registers_bench.sv ----
/*
  Self-checking bench of the converter register bank against a model.
  Assumes the host model owns the register port; SETTLE_CNT shortened to 20.
*/
`timescale 1ns/10ps
module adc_control_status_registers_bench
  import adc_regs_pkg::*;
;
  localparam int   SETTLE = 20;
  localparam logic PART   = 1'b0; // Arbitrary identity value
  logic              clock, rst, wr_strobe, rd_strobe, sample_valid, mod_tick, mod_over_fs;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data, sample_mag, digital_gain, overrange_threshold;
  logic [CONV_W-1:0] conv_result, rd_data;
  logic [DECIM_W-1:0] decimation_setting;
  logic              rd_valid, sync_start, power_off_bit, low_power_flag, ref_buf_off;
  logic              ref_bypass, input_amp_disable, filter_settled, overrange_flag;
  int                miscompares, checks, cycles, sel_m, seed;
  logic [15:0]       ctrl_m, gain_m, thr_m, t;
  logic              settled_m, overrange_m;

  adc_control_status_registers #(.SETTLE_CNT(SETTLE), .PART_IDENT(PART)) DUT (
    .clock(clock), .rst(rst), .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_strobe(rd_strobe), .conv_result(conv_result), .decimation_setting(decimation_setting),
    .sample_valid(sample_valid), .sample_mag(sample_mag), .mod_tick(mod_tick),
    .mod_over_fs(mod_over_fs), .rd_data(rd_data), .rd_valid(rd_valid),
    .sync_start(sync_start), .power_off_bit(power_off_bit), .low_power_flag(low_power_flag),
    .ref_buf_off(ref_buf_off), .ref_bypass(ref_bypass),
    .input_amp_disable(input_amp_disable), .digital_gain(digital_gain),
    .overrange_threshold(overrange_threshold), .filter_settled(filter_settled),
    .overrange_flag(overrange_flag));

  reg_host_model host (.clock(clock), .rd_valid(rd_valid), .rd_data(rd_data),
    .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data), .rd_strobe(rd_strobe));

  // ---------------------------------------------------------------
  // Clock and hang guard
  // ---------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      $display("[ERR] %0t run did not finish", $time);
      test_done();
    end
  end

  // ---------------------------------------------------------------
  // Checking helpers and model
  // ---------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [15:0] status_m();
    logic [15:0] s;
    s = 16'h4040;
    s[15] = PART;
    s[10] = settled_m;
    s[8] = overrange_m;
    s[4] = !ctrl_m[1] && !ctrl_m[3];
    s[3] = !ctrl_m[0] && !ctrl_m[3];
    s[2] = ctrl_m[2];
    s[1:0] = decimation_setting;
    return s;
  endfunction : status_m

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    host.write_reg(a, d);
    if (a == 16'h0001) begin
      ctrl_m = d & 16'h008F;
      if (d[14]) sel_m = 1;
      else if (d[13]) sel_m = 2;
      else if (d[11]) sel_m = 3;
    end
    if (a == 16'h0004) gain_m = d;
    if (a == 16'h0005) thr_m = d;
    chk(sync_start, a == 16'h0001 && d[9]);
    chk(digital_gain, gain_m);
    chk(overrange_threshold, thr_m);
    @(negedge clock);
    chk({ref_bypass, power_off_bit, low_power_flag, ref_buf_off, input_amp_disable},
        {ctrl_m[7] & ctrl_m[1], ctrl_m[3:0]});
  endtask : wr

  task automatic rd();
    logic [31:0] q, e;
    logic        v;
    conv_result = $random(seed);
    case (sel_m)
      1: e = {thr_m, 16'h0000};
      2: e = {gain_m, 16'h0000};
      3: e = {status_m(), 16'h0000};
      default: e = conv_result;
    endcase
    host.read_reg(q, v);
    chk(v, 1'b1);
    chk(q, e);
    sel_m = 0;
  endtask : rd

  task automatic wait_settled();
    int n;
    n = 0;
    while (filter_settled !== 1'b1 && n < 60) begin
      @(negedge clock);
      n++;
    end
    chk(n >= SETTLE - 2 && n <= SETTLE + 3, 1'b1);
    settled_m = 1'b1;
  endtask : wait_settled

  task automatic sample(input logic [15:0] m);
    sample_mag = m;
    sample_valid = 1'b1;
    @(negedge clock);
    sample_valid = 1'b0;
    @(negedge clock);
  endtask : sample

  task automatic ticks(input int n, input logic o);
    repeat (n) begin
      mod_tick = 1'b1;
      mod_over_fs = o;
      @(negedge clock);
    end
    mod_tick = 1'b0;
    @(negedge clock);
  endtask : ticks

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    seed = 58396;
    {miscompares, checks, cycles, sel_m} = '0;
    {rst, sample_valid, mod_tick, mod_over_fs, settled_m, overrange_m} = 6'h3F & 6'h20;
    {sample_mag, conv_result, decimation_setting} = '0;
    {ctrl_m, gain_m, thr_m} = {16'h0000, 16'hA000, 16'hCCCC};
    repeat (4) @(negedge clock);
    rst = 1'b0;
    chk({digital_gain, overrange_threshold}, {16'hA000, 16'hCCCC});
    chk({power_off_bit, low_power_flag, ref_buf_off, input_amp_disable}, 4'h0);
    chk(filter_settled, 1'b0);
    wait_settled();
    rd();
    wr(16'h0004, $random(seed));
    wr(16'h0005, $random(seed));
    for (int b = 11; b <= 14; b++) begin
      if (b != 12) begin
        wr(16'h0001, (16'h0001 << b) | ($random(seed) & 16'h0087));
        rd();
        rd();
      end
    end
    wr(16'h0002, $random(seed));
    wr(16'h0000, $random(seed));
    wr(16'h0001, 16'h2000);
    rd();
    for (int d = 0; d < 4; d++) begin
      decimation_setting = d[1:0];
      wr(16'h0001, 16'h0800 | ($random(seed) & 16'h0087));
      rd();
    end
    wr(16'h0001, 16'h0208);
    settled_m = 1'b0;
    chk(filter_settled, 1'b0);
    // Status read while still powered down
    wr(16'h0001, 16'h0808);
    rd();
    wr(16'h0001, 16'h0000);
    wait_settled();
    t = 16'h1000 + ($random(seed) & 16'h0FFF);
    wr(16'h0005, t);
    sample(t + 16'h0001);
    chk(overrange_flag, 1'b1);
    overrange_m = 1'b1;
    wr(16'h0001, 16'h0800);
    rd();
    sample(t);
    chk(overrange_flag, 1'b0);
    overrange_m = 1'b0;
    ticks(1, 1'b0);
    ticks(4, 1'b1);
    chk(overrange_flag, 1'b0);
    ticks(1, 1'b1);
    chk(overrange_flag, 1'b1);
    sample(16'h0000);
    ticks(1, 1'b0);
    ticks(4, 1'b1);
    ticks(1, 1'b0);
    ticks(4, 1'b1);
    chk(overrange_flag, 1'b0);
    test_done();
  end
endmodule : adc_control_status_registers_bench
